/* File: bench/testbench.sv */
// Self-checking bench for the skip, swap, exclusive-or and table read unit
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic issue = 1'b0;
    ssxte_pkg::ssxte_op_t op = ssxte_pkg::SSXTE_OP_NONE;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] imm = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [10:0] instr_addr = 11'h000;
    logic [7:0] table_pointer = 8'h00;
    logic [13:0] rom_rdata = 14'h0000;
    logic [7:0] acc, mem_wdata, exp_acc;
    logic [5:0] table_high_byte_latch;
    logic [10:0] rom_addr;
    logic zero_flag, mem_we, rom_re, flush, busy, exp_z;
    int err_total = 0;
    int comparisons = 0;
    localparam ssxte_pkg::ssxte_op_t NIB = ssxte_pkg::SSXTE_OP_NIBSWAP;
    localparam ssxte_pkg::ssxte_op_t XMEM = ssxte_pkg::SSXTE_OP_XORMEM;
    ssxte_exec u_ssxte_exec (.clk(clk), .arst_n(arst_n), .issue(issue), .op(op), .mem_rdata(mem_rdata),
        .imm(imm), .bit_sel(bit_sel), .instr_addr(instr_addr), .table_pointer(table_pointer),
        .rom_rdata(rom_rdata), .acc(acc), .zero_flag(zero_flag), .table_high_byte_latch(table_high_byte_latch),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .rom_re(rom_re), .rom_addr(rom_addr), .flush(flush), .busy(busy));
    always #2.5 clk = ~clk;
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    // Issue one instruction; returns just after the edge that takes it
    task automatic send(ssxte_pkg::ssxte_op_t o, logic [7:0] m, logic [7:0] im, logic [2:0] bs);
        @(posedge clk);
        issue <= 1'b1;
        op <= o;
        mem_rdata <= m;
        imm <= im;
        bit_sel <= bs;
        @(posedge clk);
        issue <= 1'b0;
        op <= ssxte_pkg::SSXTE_OP_NONE;
        mem_rdata <= ~m;
        #1;
    endtask
    task automatic swap_case(logic [7:0] m);
        send(NIB, m, 8'h00, 3'h0);
        exp_acc = {m[3:0], m[7:4]};
        chk(acc, exp_acc, "swap acc");
        chk(zero_flag, exp_z, "swap flag");
        chk(mem_we, 1'b0, "swap write");
    endtask
    task automatic skip_case(ssxte_pkg::ssxte_op_t o, logic [7:0] m, logic [2:0] bs, logic taken);
        send(o, m, 8'h00, bs);
        if (o == ssxte_pkg::SSXTE_OP_MVSKZ) exp_acc = m;
        chk(acc, exp_acc, "skip acc");
        chk(flush, taken, "skip flush");
        chk(busy, taken, "skip dummy");
        chk(zero_flag, exp_z, "skip flag");
        @(posedge clk);
        #1;
        chk({flush, busy}, 2'b00, "skip end");
    endtask
    task automatic bit_sweep();
        logic [7:0] pat;
        pat = 8'ha5;
        for (int i = 0; i < 8; i++) skip_case(ssxte_pkg::SSXTE_OP_BITSKZ, pat, 3'(i), ~pat[i]);
    endtask
    task automatic refused();
        @(posedge clk);
        issue <= 1'b1;
        op <= ssxte_pkg::SSXTE_OP_SKZ;
        mem_rdata <= 8'h00;
        @(posedge clk);
        op <= ssxte_pkg::SSXTE_OP_XORI;
        imm <= 8'hff;
        @(posedge clk);
        issue <= 1'b0;
        #1;
        chk({acc, zero_flag, busy}, {exp_acc, exp_z, 1'b0}, "issue during dummy");
    endtask
    task automatic table_case(logic last, logic [10:0] ia, logic [7:0] tp, logic [13:0] w);
        @(posedge clk);
        instr_addr <= ia;
        table_pointer <= tp;
        rom_rdata <= w;
        send(last ? ssxte_pkg::SSXTE_OP_TRDL : ssxte_pkg::SSXTE_OP_TRDC, 8'h00, 8'h00, 3'h0);
        chk({rom_re, busy, mem_we}, 3'b110, "table fetch");
        chk(rom_addr, {last ? 3'h7 : ia[10:8], tp}, "table addr");
        @(posedge clk);
        rom_rdata <= ~w;
        #1;
        chk({mem_we, mem_wdata}, {1'b1, w[7:0]}, "table low");
        chk(table_high_byte_latch, w[13:8], "table high");
        chk({zero_flag, acc}, {exp_z, exp_acc}, "table flags");
    endtask
    task automatic xor_case(ssxte_pkg::ssxte_op_t o, logic [7:0] v);
        logic [7:0] res;
        res = exp_acc ^ v;
        send(o, (o == ssxte_pkg::SSXTE_OP_XORI) ? ~v : v, (o == ssxte_pkg::SSXTE_OP_XORI) ? v : ~v, 3'h0);
        if (o != XMEM) exp_acc = res;
        exp_z = (res == 8'h00);
        chk(acc, exp_acc, "xor acc");
        chk(zero_flag, exp_z, "xor zero");
        chk({mem_we, mem_wdata & {8{o == XMEM}}}, {o == XMEM, res & {8{o == XMEM}}}, "xor mem");
    endtask
    initial begin
        #100000;
        err_total++;
        close_out();
    end
    initial begin
        exp_acc = 8'h00;
        exp_z = 1'b0;
        repeat (20) @(posedge clk);
        chk({acc, zero_flag, table_high_byte_latch},
            {ssxte_pkg::ACC_RESET, ssxte_pkg::ZERO_RESET, ssxte_pkg::HIGH_RESET}, "reset values");
        chk({mem_we, rom_re, flush, busy, rom_addr}, 15'h0000, "reset strobes");
        chk(mem_wdata, 8'h00, "reset write data");
        arst_n <= 1'b1;
        swap_case(8'h5c);
        xor_case(ssxte_pkg::SSXTE_OP_XORA, 8'h0f);
        xor_case(XMEM, 8'hca);
        xor_case(ssxte_pkg::SSXTE_OP_XORI, 8'h3a);
        xor_case(ssxte_pkg::SSXTE_OP_XORA, 8'hf0);
        swap_case(8'h81);
        skip_case(ssxte_pkg::SSXTE_OP_SKZ, 8'h00, 3'h0, 1'b1);
        skip_case(ssxte_pkg::SSXTE_OP_SKZ, 8'h80, 3'h0, 1'b0);
        skip_case(ssxte_pkg::SSXTE_OP_MVSKZ, 8'h01, 3'h0, 1'b0);
        skip_case(ssxte_pkg::SSXTE_OP_MVSKZ, 8'h00, 3'h0, 1'b1);
        bit_sweep();
        refused();
        table_case(1'b0, 11'h5a3, 8'h7e, 14'h2a5c);
        table_case(1'b1, 11'h1ff, 8'hff, 14'h15a3);
        close_out();
    end
endmodule

/* File: verilog/ssxte_exec.sv */
// Execution unit for nibble swap, zero skips, table reads and exclusive-or instructions
// Functional notes
// - Nibble swap to accumulator puts memory bits 7..4 into acc bits 3..0 and bits 3..0 into acc bits 7..4.
// - Nibble swap to accumulator leaves the memory byte and every flag unchanged.
// - Skip-if-zero skips the next instruction when the addressed byte is zero.
// - A taken skip discards the prefetched instruction and adds one dummy cycle; an untaken skip takes one cycle.
// - Move-then-skip-if-zero copies the byte to the accumulator and skips when it is zero.
// - Bit-test skip skips when the selected bit of the byte is zero, with the same two-cycle timing.
// - Current-page table read writes the word's low byte to memory and its upper bits to the high-byte latch.
// - Last-page table read does the same using the last program memory page.
// - Exclusive-or with memory writes acc xor byte into the accumulator.
// - Exclusive-or into memory writes acc xor byte to memory and keeps the accumulator.
// - Exclusive-or immediate writes acc xor immediate into the accumulator.
// - Every exclusive-or variant updates only the zero flag from its eight-bit result.
`timescale 1ns/100ps
module ssxte_exec #(
    parameter int PC_W = ssxte_pkg::PC_W,
    parameter int ROM_W = ssxte_pkg::ROM_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic issue,
    input wire ssxte_pkg::ssxte_op_t op,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    input wire logic [PC_W-1:0] instr_addr,
    input wire logic [7:0] table_pointer,
    input wire logic [ROM_W-1:0] rom_rdata,
    output logic [7:0] acc,
    output logic zero_flag,
    output logic [ROM_W-9:0] table_high_byte_latch,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    output logic rom_re,
    output logic [PC_W-1:0] rom_addr,
    output logic flush,
    output logic busy
);
    ssxte_pkg::ssxte_state_t state;
    ssxte_pkg::ssxte_state_t next_state;

    // Opcode decode, qualified by issue so that an idle bus decodes to nothing
    wire is_swap = issue && op == ssxte_pkg::SSXTE_OP_NIBSWAP;
    wire is_skz = issue && op == ssxte_pkg::SSXTE_OP_SKZ;
    wire is_mvskz = issue && op == ssxte_pkg::SSXTE_OP_MVSKZ;
    wire is_bitskz = issue && op == ssxte_pkg::SSXTE_OP_BITSKZ;
    wire is_trdc = issue && op == ssxte_pkg::SSXTE_OP_TRDC;
    wire is_trdl = issue && op == ssxte_pkg::SSXTE_OP_TRDL;
    wire is_xora = issue && op == ssxte_pkg::SSXTE_OP_XORA;
    wire is_xormem = issue && op == ssxte_pkg::SSXTE_OP_XORMEM;
    wire is_xori = issue && op == ssxte_pkg::SSXTE_OP_XORI;
    wire can_issue = state == ssxte_pkg::SSXTE_ST_IDLE;

    wire byte_zero = mem_rdata == 8'h00;
    wire bit_zero = ~mem_rdata[bit_sel];
    wire [7:0] swapped = {mem_rdata[3:0], mem_rdata[7:4]};
    wire skip_take = can_issue && ((is_skz && byte_zero) || (is_mvskz && byte_zero) || (is_bitskz && bit_zero));
    wire table_go = can_issue && (is_trdc || is_trdl);
    wire [7:0] xor_src = is_xori ? imm : mem_rdata;
    wire [7:0] xor_res = acc ^ xor_src;
    wire xor_any = can_issue && (is_xora || is_xormem || is_xori);
    // Page bits come from the executing address or are all ones for the last page
    wire [PC_W-9:0] cur_page = instr_addr[PC_W-1:8];
    wire [PC_W-9:0] last_page = '1;
    wire [PC_W-1:0] next_rom_addr = {is_trdl ? last_page : cur_page, table_pointer};

    wire acc_load = can_issue && (is_swap || is_mvskz || is_xora || is_xori);
    wire [7:0] next_acc = is_swap ? swapped : (is_mvskz ? mem_rdata : xor_res);

    // A taken skip or a table read owns the following cycle; an issue there is dropped
    always_comb begin
        next_state = state;
        unique case (state)
            ssxte_pkg::SSXTE_ST_IDLE: begin
                if (skip_take) begin
                    next_state = ssxte_pkg::SSXTE_ST_DUMMY;
                end else if (table_go) begin
                    next_state = ssxte_pkg::SSXTE_ST_TABLE;
                end
            end
            ssxte_pkg::SSXTE_ST_DUMMY: next_state = ssxte_pkg::SSXTE_ST_IDLE;
            ssxte_pkg::SSXTE_ST_TABLE: next_state = ssxte_pkg::SSXTE_ST_IDLE;
            default: next_state = ssxte_pkg::SSXTE_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ssxte_pkg::SSXTE_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc <= ssxte_pkg::ACC_RESET;
        end else if (acc_load) begin
            acc <= next_acc;
        end
    end

    // Only exclusive-or touches the zero flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zero_flag <= ssxte_pkg::ZERO_RESET;
        end else if (xor_any) begin
            zero_flag <= xor_res == 8'h00;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flush <= 1'b0;
            busy <= 1'b0;
            rom_re <= 1'b0;
            rom_addr <= '0;
        end else begin
            flush <= skip_take;
            busy <= skip_take || table_go;
            rom_re <= table_go;
            rom_addr <= table_go ? next_rom_addr : rom_addr;
        end
    end

    // Table word is written in the second cycle, low byte to memory, rest to the latch
    wire table_done = state == ssxte_pkg::SSXTE_ST_TABLE;
    wire xormem_go = can_issue && is_xormem;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
            table_high_byte_latch <= '0;
        end else begin
            mem_we <= table_done || xormem_go;
            if (table_done) begin
                mem_wdata <= rom_rdata[7:0];
                table_high_byte_latch <= rom_rdata[ROM_W-1:8];
            end else if (xormem_go) begin
                mem_wdata <= xor_res;
            end
        end
    end

    // Skip timing: flush and busy for exactly one cycle, nothing else moves in the dummy cycle
    a_skip_flush: assert property (@(posedge clk) disable iff (!arst_n)
        skip_take |=> flush && busy ##1 !flush)
        else $error("taken skip did not flush exactly once");
    a_skip_taken: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_skz && mem_rdata == 8'h00) |=> flush && busy)
        else $error("zero byte did not skip");
    a_noskip_one: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_skz && !byte_zero) |=> !flush && !busy)
        else $error("untaken skip stalled");
    a_skip_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
        skip_take |=> !mem_we && !rom_re)
        else $error("taken skip touched memory");
    a_dummy_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        (state == ssxte_pkg::SSXTE_ST_DUMMY) |=> !flush && !rom_re && !mem_we && $stable(acc))
        else $error("dummy cycle executed an instruction");

    // Nibble swap, move-then-skip and bit-test skip
    a_swap_value: assert property (@(posedge clk) disable iff (!arst_n)
        (is_swap && can_issue) |=> {acc[3:0], acc[7:4]} == $past(mem_rdata) && !mem_we)
        else $error("swap result wrong");
    a_swap_flags: assert property (@(posedge clk) disable iff (!arst_n)
        (is_swap && can_issue) |=> $stable(zero_flag))
        else $error("swap changed a flag");
    a_mvskz_acc: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_mvskz) |=> acc == $past(mem_rdata))
        else $error("move-skip did not load acc");
    a_mvskz_skip: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_mvskz) |=> flush == ($past(mem_rdata) == 8'h00) && busy == flush)
        else $error("move-skip decision wrong");
    a_bit_skip: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_bitskz && !bit_zero) |=> !flush)
        else $error("bit skip taken on a one bit");
    a_bit_take: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_bitskz) |=> flush == ((($past(mem_rdata) >> $past(bit_sel)) & 8'h01) == 8'h00))
        else $error("bit skip decision wrong");

    // Table reads: address, two-cycle timing and the split of the program word
    a_table_two: assert property (@(posedge clk) disable iff (!arst_n)
        table_go |=> rom_re && busy ##1 mem_we && {table_high_byte_latch, mem_wdata} == $past(rom_rdata))
        else $error("table read timing or data wrong");
    a_rom_once: assert property (@(posedge clk) disable iff (!arst_n)
        rom_re |=> !rom_re)
        else $error("program memory read longer than one cycle");
    a_cur_page: assert property (@(posedge clk) disable iff (!arst_n)
        (table_go && is_trdc) |=> rom_addr[7:0] == $past(table_pointer) && (rom_addr >> 8) == ($past(instr_addr) >> 8))
        else $error("current page address wrong");
    a_last_page: assert property (@(posedge clk) disable iff (!arst_n)
        (table_go && is_trdl) |=> rom_addr[PC_W-1:8] == '1 && rom_addr[7:0] == $past(table_pointer))
        else $error("last page address wrong");

    // Exclusive-or variants and flag behaviour
    a_xora_acc: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_xora) |=> acc == ($past(acc) ^ $past(mem_rdata)))
        else $error("xor with memory result wrong");
    a_xori_acc: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_xori) |=> acc == ($past(acc) ^ $past(imm)))
        else $error("xor immediate result wrong");
    a_xor_zero: assert property (@(posedge clk) disable iff (!arst_n)
        xor_any |=> zero_flag == ((mem_we ? mem_wdata : acc) == 8'h00))
        else $error("xor zero flag wrong");
    a_xor_mem_acc: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_xormem) |=> $stable(acc) && mem_we)
        else $error("xor into memory changed acc");
    a_xor_mem_data: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && is_xormem) |=> mem_wdata == ($past(acc) ^ $past(mem_rdata)))
        else $error("xor into memory data wrong");
    a_skip_flags: assert property (@(posedge clk) disable iff (!arst_n)
        (can_issue && (is_skz || is_mvskz || is_bitskz || is_trdc || is_trdl)) |=> $stable(zero_flag))
        else $error("skip or table read changed a flag");

    c_skip_taken: cover property (@(posedge clk) disable iff (!arst_n) skip_take);
    c_bit_skip: cover property (@(posedge clk) disable iff (!arst_n) can_issue && is_bitskz && bit_zero);
    c_table_cur: cover property (@(posedge clk) disable iff (!arst_n) table_go && is_trdc ##2 mem_we);
    c_table_last: cover property (@(posedge clk) disable iff (!arst_n) table_go && is_trdl ##2 mem_we);
    c_xor_zero: cover property (@(posedge clk) disable iff (!arst_n) xor_any && xor_res == 8'h00);
endmodule

/* File: verilog/ssxte_pkg.sv */
// Package with opcodes, widths and timing constants for the skip/swap/xor/table execution unit
package ssxte_pkg;
    localparam int DATA_W = 8;
    localparam int ROM_W = 14;
    localparam int PC_W = 11;
    localparam int TBL_W = 8;
    localparam int HIGH_W = ROM_W - DATA_W;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [5:0] HIGH_RESET = 6'h00;
    localparam logic ZERO_RESET = 1'b0;
    // Instruction cycles per operation
    localparam int CYC_SINGLE = 1;
    localparam int CYC_DOUBLE = 2;

    typedef enum logic [3:0] {
        SSXTE_OP_NONE = 4'h0,
        SSXTE_OP_NIBSWAP = 4'h1,
        SSXTE_OP_SKZ = 4'h2,
        SSXTE_OP_MVSKZ = 4'h3,
        SSXTE_OP_BITSKZ = 4'h4,
        SSXTE_OP_TRDC = 4'h5,
        SSXTE_OP_TRDL = 4'h6,
        SSXTE_OP_XORA = 4'h7,
        SSXTE_OP_XORMEM = 4'h8,
        SSXTE_OP_XORI = 4'h9
    } ssxte_op_t;

    typedef enum logic [1:0] {
        SSXTE_ST_IDLE = 2'b00,
        SSXTE_ST_DUMMY = 2'b01,
        SSXTE_ST_TABLE = 2'b10
    } ssxte_state_t;
endpackage
